// file: dv/fcsm_flash_model.sv
// Behavioural byte-wide flash device on the host pins.
`timescale 1ns/10ps
module fcsm_flash_model #(
    // Identity values are arbitrary.
    parameter [7:0] MFR_CODE = 8'h5e,
    parameter [7:0] DEV_CODE = 8'hc3,
    parameter [7:0] CONT_CODE = 8'h6a,
    parameter [7:0] PROT_SECT = 8'h02
) (
    input wire ce_n_in,
    input wire we_n_in,
    input wire oe_n_in,
    input wire [18:0] addr_in,
    input wire [7:0] dq_in,
    output wire [7:0] dq_out,
    output reg [7:0] err_count_out = 8'h00
);
    reg [7:0] mem [0:255];
    reg [7:0] rd_val = 8'h00;
    reg [7:0] cmd = 8'h00;
    reg [7:0] pd = 8'h00;
    reg [7:0] d = 8'h00;
    reg [18:0] a = 19'h0;
    reg [2:0] stp = 3'd0;
    reg [1:0] st = 2'd0;
    reg tog = 1'b0;
    reg tle = 1'b0;
    reg lock = 1'b1;
    reg ok = 1'b1;
    realtime t_on = 0.0;
    integer cnt = 0;
    integer i;
    wire wr_act = !ce_n_in && !we_n_in && oe_n_in;
    initial begin
        for (i = 0; i < 256; i = i + 1)
            mem[i] = i[7:0] ^ 8'h3c;
        #1 lock = wr_act !== 1'b0;
    end
    always @(posedge wr_act) begin
        a = addr_in;
        t_on = $realtime;
    end
    always @(negedge wr_act) begin
        d = dq_in;
        ok = 1'b1;
        if (lock || $realtime - t_on < 5.0) begin
            lock = 1'b0;
        end else if (st == 2'd2) begin
            ok = tle && d == 8'hf0;
            st = ok ? 2'd0 : st;
            tle = tle && !ok;
        end else if (stp == 3'd3 && cmd == 8'ha0) begin
            tle = |(d & ~mem[a[7:0]]);
            mem[a[7:0]] = mem[a[7:0]] & d;
            pd = d;
            st = 2'd2;
        end else if (d == 8'hf0) begin
            st = 2'd0;
            stp = 3'd0;
        end else begin
            case (stp)
                3'd1, 3'd4: ok = a[10:0] == 11'h2aa && d == 8'h55;
                3'd2: ok = a[10:0] == 11'h555
                    && (d == 8'h90 || d == 8'ha0 || d == 8'h80);
                3'd5: ok = a[10:0] == 11'h555 && d == 8'h10;
                default: ok = a[10:0] == 11'h555 && d == 8'haa;
            endcase
            ok = ok && st == 2'd0;
            cmd = stp == 3'd2 ? d : cmd;
            stp = ok ? stp + 3'd1 : 3'd0;
            st = ok && stp == 3'd3 && d == 8'h90 ? 2'd1 : st;
            st = ok ? st : 2'd0;
            if (stp == 3'd6) begin
                for (i = 0; i < 256; i = i + 1)
                    mem[i] = 8'hff;
                pd = 8'hff;
                tle = 1'b0;
                st = 2'd2;
            end
        end
        stp = st == 2'd0 ? stp : 3'd0;
        cnt = 0;
        err_count_out = err_count_out + {7'h00, !ok};
    end
    always @(negedge oe_n_in) begin
        if (!ce_n_in && st == 2'd2) begin
            rd_val = {~pd[7], tog, tle, 5'h00};
            tog = ~tog;
            cnt = tle ? cnt : cnt + 1;
            st = cnt == 3 ? 2'd0 : st;
        end else if (!ce_n_in && st == 2'd1) begin
            case (addr_in[7:0])
                8'h00: rd_val = MFR_CODE;
                8'h01: rd_val = DEV_CODE;
                8'h03: rd_val = CONT_CODE;
                default: rd_val = {7'h00, PROT_SECT[addr_in[18:16]]};
            endcase
        end else begin
            rd_val = mem[addr_in[7:0]];
        end
    end
    // A released bus shows the inverse so a stale byte cannot pass.
    assign dq_out = !ce_n_in && !oe_n_in ? rd_val : ~rd_val;
endmodule

// file: dv/fcsm_host_chk.sv
// Checker of the flash pin protocol driven by the host controller.
`timescale 1ns/10ps
module fcsm_host_chk (
    input wire mclk_in,
    input wire srst_in,
    input wire flash_ce_n_out,
    input wire flash_we_n_out,
    input wire flash_oe_n_out,
    input wire [18:0] flash_addr_out,
    input wire [7:0] flash_dq_out,
    input wire flash_dq_oe_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (srst_in);
    sequence s_we_pulse;
        (!flash_we_n_out) [*4] ##1 flash_we_n_out;
    endsequence
    sequence s_rd_access;
        (!flash_oe_n_out) [*8] ##1 !flash_oe_n_out ##1 flash_oe_n_out
            ##1 flash_ce_n_out;
    endsequence
    a_idle_reset: assert property (disable iff (1'b0)
        srst_in |=> flash_ce_n_out && flash_we_n_out && !flash_dq_oe_out)
        else $error("pins not idle after reset");
    a_write_qual: assert property (
        !flash_we_n_out |-> !flash_ce_n_out && flash_oe_n_out
            && flash_dq_oe_out)
        else $error("write strobe without qualifiers");
    a_read_drive: assert property (
        !flash_oe_n_out |-> !flash_dq_oe_out && flash_we_n_out)
        else $error("output enable during a write");
    a_addr_stable: assert property (
        !flash_ce_n_out && !$past(flash_ce_n_out) |-> $stable(flash_addr_out))
        else $error("address moved inside a cycle");
    a_data_stable: assert property (
        flash_dq_oe_out && $past(flash_dq_oe_out) |-> $stable(flash_dq_out))
        else $error("write data moved inside a cycle");
    a_we_width: assert property (
        $fell(flash_we_n_out) |-> s_we_pulse)
        else $error("write pulse not four cycles");
    a_ce_release: assert property (
        $rose(flash_we_n_out) |=> $rose(flash_ce_n_out) && !flash_dq_oe_out)
        else $error("chip enable not released after write");
    a_rd_shape: assert property (
        $fell(flash_oe_n_out) |-> s_rd_access)
        else $error("read access shape wrong");
endmodule

// file: dv/test_fcsm_host.sv
// Self-checking bench of the flash command sequencer host controller.
`timescale 1ns/10ps
`include "fcsm_consts.vh"
`define CHK(nm, e, g) \
    begin \
        num_checks = num_checks + 1; \
        if ((g) !== (e)) begin \
            bad_count = bad_count + 1; \
            $display("ERROR %s expected %h seen %h", nm, e, g); \
        end \
    end
module test_fcsm_host;
    // Identity values are arbitrary and must match the model's.
    localparam [7:0] MFR = 8'h5e;
    localparam [7:0] DEV = 8'hc3;
    localparam [7:0] CONT = 8'h6a;
    reg mclk_in = 1'b0;
    reg srst_in = 1'b1;
    reg [3:0] reg_addr_in = 4'h0;
    reg [31:0] reg_wdata_in = 32'h0;
    reg reg_wr_in = 1'b0;
    reg reg_rd_in = 1'b0;
    wire [31:0] reg_rdata_out;
    wire ce_n, we_n, oe_n, dq_oe;
    wire [18:0] faddr;
    wire [7:0] hdq, mdq, dq_bus, merr;
    integer bad_count = 0;
    integer num_checks = 0;
    integer k;
    reg [31:0] rv;
    assign dq_bus = dq_oe ? hdq : mdq;
    always #5 mclk_in = ~mclk_in;
    fcsm_host dut_u (.mclk_in(mclk_in), .srst_in(srst_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .flash_ce_n_out(ce_n),
        .flash_we_n_out(we_n), .flash_oe_n_out(oe_n),
        .flash_addr_out(faddr), .flash_dq_out(hdq),
        .flash_dq_oe_out(dq_oe), .flash_dq_in(dq_bus));
    fcsm_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .CONT_CODE(CONT),
        .PROT_SECT(8'h02)) mdl_u (.ce_n_in(ce_n), .we_n_in(we_n),
        .oe_n_in(oe_n), .addr_in(faddr), .dq_in(dq_bus), .dq_out(mdq),
        .err_count_out(merr));
    task summarize;
        begin
            $display("checks %0d errors %0d", num_checks, bad_count);
            if (bad_count == 0 && num_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task wr(input [3:0] a, input [31:0] d);
        begin
            @(posedge mclk_in);
            reg_addr_in <= a;
            reg_wdata_in <= d;
            reg_wr_in <= 1'b1;
            @(posedge mclk_in);
            reg_wr_in <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, output [31:0] d);
        begin
            @(posedge mclk_in);
            reg_addr_in <= a;
            reg_rd_in <= 1'b1;
            @(posedge mclk_in);
            reg_rd_in <= 1'b0;
            #1 d = reg_rdata_out;
        end
    endtask
    // Polls until idle, then leaves the final status word in rv.
    task wait_idle;
        begin
            repeat (3) @(posedge mclk_in);
            rv = 32'h1;
            for (k = 0; k < 400 && rv[`FCSM_ST_BUSY] !== 1'b0; k = k + 1)
                rd(`FCSM_REG_STATUS, rv);
            `CHK("busy", 1'b0, rv[`FCSM_ST_BUSY])
        end
    endtask
    task op(input [2:0] c, input [18:0] a, input [7:0] w);
        begin
            wr(`FCSM_REG_ADDR, {13'h0, a});
            wr(`FCSM_REG_WDATA, {24'h0, w});
            wr(`FCSM_REG_CTRL, {29'h0, c});
            wait_idle;
        end
    endtask
    task chk_op(input [2:0] c, input [18:0] a, input [7:0] e);
        begin
            op(c, a, 8'h00);
            `CHK("rdata", e, rv[15:8])
        end
    endtask
    initial begin
        repeat (6) @(posedge mclk_in);
        srst_in <= 1'b0;
        rd(`FCSM_REG_STATUS, rv);
        `CHK("status", 32'h0, rv)
        rd(4'h7, rv);
        `CHK("unmapped", 32'h0, rv)
        `CHK("idle", 3'b110, {ce_n, we_n, dq_oe})
        chk_op(`FCSM_OP_READ, 19'h00010, 8'h2c);
        chk_op(`FCSM_OP_AUTOSEL, 19'h00000, MFR);
        chk_op(`FCSM_OP_AUTOSEL, 19'h00001, DEV);
        chk_op(`FCSM_OP_AUTOSEL, 19'h00003, CONT);
        chk_op(`FCSM_OP_AUTOSEL, 19'h10002, 8'h01);
        chk_op(`FCSM_OP_AUTOSEL, 19'h30002, 8'h00);
        chk_op(`FCSM_OP_READ, 19'h00010, 8'h2c);
        wr(`FCSM_REG_ADDR, 32'h21);
        wr(`FCSM_REG_WDATA, 32'h0);
        wr(`FCSM_REG_CTRL, {29'h0, `FCSM_OP_PROG});
        // This address write lands while busy and must be dropped.
        wr(`FCSM_REG_ADDR, 32'h40);
        wait_idle;
        `CHK("prog flags", 3'b010, rv[2:0])
        rd(`FCSM_REG_ADDR, rv);
        `CHK("addr reg", 32'h21, rv)
        wr(`FCSM_REG_CTRL, {29'h0, `FCSM_OP_READ});
        wait_idle;
        `CHK("prog data", 8'h00, rv[15:8])
        op(`FCSM_OP_PROG, 19'h00021, 8'hff);
        `CHK("limit flags", 3'b110, rv[2:0])
        rd(`FCSM_REG_WDATA, rv);
        `CHK("wdata reg", 32'hff, rv)
        chk_op(`FCSM_OP_READ, 19'h00021, 8'h00);
        op(`FCSM_OP_RESET, 19'h7ffff, 8'h00);
        `CHK("reset flags", 2'b10, rv[1:0])
        chk_op(`FCSM_OP_READ, 19'h00010, 8'h2c);
        op(`FCSM_OP_ERASE, 19'h00000, 8'h00);
        `CHK("erase flags", 2'b10, rv[1:0])
        chk_op(`FCSM_OP_READ, 19'h00021, 8'hff);
        chk_op(`FCSM_OP_READ, 19'h00010, 8'hff);
        `CHK("bad sequences", 8'h00, merr)
        summarize;
    end
    initial begin
        #400000;
        bad_count = bad_count + 1;
        summarize;
    end
endmodule
bind fcsm_host fcsm_host_chk chk_u (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .flash_ce_n_out(flash_ce_n_out),
    .flash_we_n_out(flash_we_n_out),
    .flash_oe_n_out(flash_oe_n_out),
    .flash_addr_out(flash_addr_out),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe_out(flash_dq_oe_out)
);

// file: inc/fcsm_consts.vh
// Constants of the flash command sequencer host controller.
// Behaviour
// - Writes only with chip-enable and write-enable low, output-enable high.
// - Autoselect is always left with a reset command write.
// - Time-limit flag seen while toggling makes the host write reset if the next poll still toggles.
// - Program is two unlocks, A0 set-up, then address with data.
// - Chip erase is two unlocks, 80, two unlocks, then 10.
`ifndef FCSM_CONSTS_VH
`define FCSM_CONSTS_VH

`define FCSM_REG_CTRL 4'h0
`define FCSM_REG_ADDR 4'h1
`define FCSM_REG_WDATA 4'h2
`define FCSM_REG_STATUS 4'h3

`define FCSM_OP_READ 3'h0
`define FCSM_OP_RESET 3'h1
`define FCSM_OP_AUTOSEL 3'h2
`define FCSM_OP_PROG 3'h3
`define FCSM_OP_ERASE 3'h4

`define FCSM_UNLOCK1_ADDR 19'h00555
`define FCSM_UNLOCK2_ADDR 19'h002aa
`define FCSM_UNLOCK1_DATA 8'haa
`define FCSM_UNLOCK2_DATA 8'h55
`define FCSM_CMD_RESET 8'hf0
`define FCSM_CMD_AUTOSEL 8'h90
`define FCSM_CMD_PROG 8'ha0
`define FCSM_CMD_ERASE_SETUP 8'h80
`define FCSM_CMD_CHIP_ERASE 8'h10

`define FCSM_ST_BUSY 0
`define FCSM_ST_DONE 1
`define FCSM_ST_TLE 2
`define FCSM_ST_RDATA_LO 8
`define FCSM_BIT_TOGGLE 6
`define FCSM_BIT_TLE 5

`define FCSM_CLK_PERIOD_NS 10
`define FCSM_T_WP_NS 35
`define FCSM_T_ACC_NS 70
`define FCSM_WP_CYC \
    ((`FCSM_T_WP_NS + `FCSM_CLK_PERIOD_NS - 1) / `FCSM_CLK_PERIOD_NS)
`define FCSM_ACC_CYC \
    ((`FCSM_T_ACC_NS + `FCSM_CLK_PERIOD_NS - 1) / `FCSM_CLK_PERIOD_NS)
`define FCSM_SYNC_CYC 2

`endif

// file: rtl/fcsm_bus_cycle.v
// One timed read or write cycle on the flash strobes, address and data.
`timescale 1ns/10ps
`include "fcsm_consts.vh"
module fcsm_bus_cycle (
    input wire mclk_in,
    input wire srst_in,
    input wire start_in,
    input wire is_read_in,
    input wire [18:0] addr_in,
    input wire [7:0] data_in,
    input wire [7:0] dq_sync_in,
    output reg done_out,
    output reg [7:0] rdata_out,
    output reg ce_n_out,
    output reg we_n_out,
    output reg oe_n_out,
    output reg [18:0] addr_out,
    output reg [7:0] dq_out,
    output reg dq_oe_out
);
    localparam S_IDLE = 2'd0;
    localparam S_SETUP = 2'd1;
    localparam S_STROBE = 2'd2;
    localparam S_HOLD = 2'd3;
    localparam integer WP_I = `FCSM_WP_CYC - 1;
    localparam integer RD_I = `FCSM_ACC_CYC + `FCSM_SYNC_CYC - 1;
    localparam [3:0] WP_CNT = WP_I[3:0];
    localparam [3:0] RD_CNT = RD_I[3:0];

    reg [1:0] state;
    reg [3:0] cnt;
    reg is_rd;

    always @(posedge mclk_in) begin
        if (srst_in) begin
            state <= S_IDLE;
            cnt <= 4'h0;
            is_rd <= 1'b0;
            done_out <= 1'b0;
            rdata_out <= 8'h00;
            ce_n_out <= 1'b1;
            we_n_out <= 1'b1;
            oe_n_out <= 1'b1;
            addr_out <= 19'h00000;
            dq_out <= 8'h00;
            dq_oe_out <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    done_out <= 1'b0;
                    if (start_in) begin
                        addr_out <= addr_in;
                        dq_out <= data_in;
                        is_rd <= is_read_in;
                        ce_n_out <= 1'b0;
                        dq_oe_out <= ~is_read_in;
                        state <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    if (is_rd) begin
                        oe_n_out <= 1'b0;
                        cnt <= RD_CNT;
                    end else begin
                        we_n_out <= 1'b0;
                        cnt <= WP_CNT;
                    end
                    state <= S_STROBE;
                end
                S_STROBE: begin
                    if (cnt == 4'h0) begin
                        if (is_rd) begin
                            rdata_out <= dq_sync_in;
                            oe_n_out <= 1'b1;
                        end else begin
                            we_n_out <= 1'b1;
                        end
                        state <= S_HOLD;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                S_HOLD: begin
                    ce_n_out <= 1'b1;
                    dq_oe_out <= 1'b0;
                    done_out <= 1'b1;
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// file: rtl/fcsm_host.v
// Host controller that runs flash command sequences for software.
`timescale 1ns/10ps
`include "fcsm_consts.vh"
module fcsm_host (
    input wire mclk_in,
    input wire srst_in,
    input wire [3:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [31:0] reg_rdata_out,
    output wire flash_ce_n_out,
    output wire flash_we_n_out,
    output wire flash_oe_n_out,
    output wire [18:0] flash_addr_out,
    output wire [7:0] flash_dq_out,
    output wire flash_dq_oe_out,
    input wire [7:0] flash_dq_in
);
    localparam S_IDLE = 3'd0;
    localparam S_ISSUE = 3'd1;
    localparam S_WAIT = 3'd2;
    localparam S_POLL = 3'd3;
    localparam S_PWAIT = 3'd4;
    localparam S_RESET = 3'd5;
    localparam S_RWAIT = 3'd6;

    reg [2:0] state;
    reg [2:0] op;
    reg [2:0] step;
    reg [18:0] user_addr;
    reg [7:0] user_data;
    reg busy;
    reg done;
    reg tle_err;
    reg tle_seen;
    reg first_poll;
    reg [7:0] last_rdata;
    reg [7:0] prev_poll;
    reg cyc_start;
    reg cyc_read;
    reg [18:0] cyc_addr;
    reg [7:0] cyc_data;
    // Word of the current step: read flag, address and data.
    reg [27:0] next_step;
    wire cyc_done;
    wire [7:0] cyc_rdata;
    wire [7:0] dq_sync;

    // Number of bus cycles in the sequence of each operation.
    function [2:0] seq_len;
        input [2:0] f_op;
        begin
            case (f_op)
                `FCSM_OP_AUTOSEL: seq_len = 3'd5;
                `FCSM_OP_PROG: seq_len = 3'd4;
                `FCSM_OP_ERASE: seq_len = 3'd6;
                default: seq_len = 3'd1;
            endcase
        end
    endfunction

    // One step as {is_read, address, data}.
    function [27:0] seq_step;
        input [2:0] f_op;
        input [2:0] f_idx;
        input [18:0] f_addr;
        input [7:0] f_data;
        begin
            seq_step = {1'b0, 19'h00000, `FCSM_CMD_RESET};
            case (f_op)
                `FCSM_OP_READ: begin
                    seq_step = {1'b1, f_addr, 8'h00};
                end
                `FCSM_OP_AUTOSEL: begin
                    case (f_idx)
                        3'd0: seq_step = {1'b0, `FCSM_UNLOCK1_ADDR,
                                          `FCSM_UNLOCK1_DATA};
                        3'd1: seq_step = {1'b0, `FCSM_UNLOCK2_ADDR,
                                          `FCSM_UNLOCK2_DATA};
                        3'd2: seq_step = {1'b0, `FCSM_UNLOCK1_ADDR,
                                          `FCSM_CMD_AUTOSEL};
                        3'd3: seq_step = {1'b1, f_addr, 8'h00};
                        // Identity mode is always closed by a reset
                        // write, so no later operation finds it open.
                        default: seq_step = {1'b0, 19'h00000,
                                             `FCSM_CMD_RESET};
                    endcase
                end
                `FCSM_OP_PROG: begin
                    case (f_idx)
                        3'd0: seq_step = {1'b0, `FCSM_UNLOCK1_ADDR,
                                          `FCSM_UNLOCK1_DATA};
                        3'd1: seq_step = {1'b0, `FCSM_UNLOCK2_ADDR,
                                          `FCSM_UNLOCK2_DATA};
                        3'd2: seq_step = {1'b0, `FCSM_UNLOCK1_ADDR,
                                          `FCSM_CMD_PROG};
                        default: seq_step = {1'b0, f_addr, f_data};
                    endcase
                end
                `FCSM_OP_ERASE: begin
                    case (f_idx)
                        3'd0, 3'd3: seq_step = {1'b0, `FCSM_UNLOCK1_ADDR,
                                                `FCSM_UNLOCK1_DATA};
                        3'd1, 3'd4: seq_step = {1'b0, `FCSM_UNLOCK2_ADDR,
                                                `FCSM_UNLOCK2_DATA};
                        3'd2: seq_step = {1'b0, `FCSM_UNLOCK1_ADDR,
                                          `FCSM_CMD_ERASE_SETUP};
                        default: seq_step = {1'b0, `FCSM_UNLOCK1_ADDR,
                                             `FCSM_CMD_CHIP_ERASE};
                    endcase
                end
                default: begin
                    // Spare op codes send a lone reset write, which is harmless except
                    // during a program or erase without time-limit, or just after A0 set-up.
                    seq_step = {1'b0, 19'h00000, `FCSM_CMD_RESET};
                end
            endcase
        end
    endfunction

    always @* begin
        next_step = seq_step(op, step, user_addr, user_data);
    end

    fcsm_sync2 u_sync (
        .mclk_in(mclk_in),
        .srst_in(srst_in),
        .d_in(flash_dq_in),
        .q_out(dq_sync)
    );

    fcsm_bus_cycle u_cycle (
        .mclk_in(mclk_in),
        .srst_in(srst_in),
        .start_in(cyc_start),
        .is_read_in(cyc_read),
        .addr_in(cyc_addr),
        .data_in(cyc_data),
        .dq_sync_in(dq_sync),
        .done_out(cyc_done),
        .rdata_out(cyc_rdata),
        .ce_n_out(flash_ce_n_out),
        .we_n_out(flash_we_n_out),
        .oe_n_out(flash_oe_n_out),
        .addr_out(flash_addr_out),
        .dq_out(flash_dq_out),
        .dq_oe_out(flash_dq_oe_out)
    );

    // Register port and sequence engine share one process, so a
    // software write and an engine step never disagree on busy.
    always @(posedge mclk_in) begin
        if (srst_in) begin
            state <= S_IDLE;
            op <= `FCSM_OP_READ;
            step <= 3'd0;
            user_addr <= 19'h00000;
            user_data <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
            tle_err <= 1'b0;
            tle_seen <= 1'b0;
            first_poll <= 1'b0;
            last_rdata <= 8'h00;
            prev_poll <= 8'h00;
            cyc_start <= 1'b0;
            cyc_read <= 1'b0;
            cyc_addr <= 19'h00000;
            cyc_data <= 8'h00;
            reg_rdata_out <= 32'h00000000;
        end else begin
            cyc_start <= 1'b0;
            reg_rdata_out <= 32'h00000000;
            // Read data is zero outside its one answer cycle, so a stale
            // word can never be mistaken for a fresh answer.
            if (reg_rd_in && reg_addr_in == `FCSM_REG_STATUS) begin
                reg_rdata_out <= {16'h0000, last_rdata, 5'h00,
                                  tle_err, done, busy};
            end else if (reg_rd_in && reg_addr_in == `FCSM_REG_ADDR) begin
                reg_rdata_out <= {13'h0000, user_addr};
            end else if (reg_rd_in && reg_addr_in == `FCSM_REG_WDATA) begin
                reg_rdata_out <= {24'h000000, user_data};
            end
            // Writes while busy are dropped so a sequence is never broken.
            if (reg_wr_in && !busy) begin
                case (reg_addr_in)
                    `FCSM_REG_CTRL: begin
                        op <= reg_wdata_in[2:0];
                        step <= 3'd0;
                        busy <= 1'b1;
                        done <= 1'b0;
                        tle_err <= 1'b0;
                        state <= S_ISSUE;
                    end
                    `FCSM_REG_ADDR: user_addr <= reg_wdata_in[18:0];
                    `FCSM_REG_WDATA: user_data <= reg_wdata_in[7:0];
                    default: begin
                    end
                endcase
            end
            case (state)
                S_IDLE: begin
                end
                S_ISSUE: begin
                    cyc_start <= 1'b1;
                    cyc_read <= next_step[27];
                    cyc_addr <= next_step[26:8];
                    cyc_data <= next_step[7:0];
                    state <= S_WAIT;
                end
                S_WAIT: begin
                    if (cyc_done) begin
                        if (cyc_read) begin
                            last_rdata <= cyc_rdata;
                        end
                        if (step == seq_len(op) - 3'd1) begin
                            if (op == `FCSM_OP_PROG ||
                                op == `FCSM_OP_ERASE) begin
                                first_poll <= 1'b1;
                                tle_seen <= 1'b0;
                                state <= S_POLL;
                            end else begin
                                busy <= 1'b0;
                                done <= 1'b1;
                                state <= S_IDLE;
                            end
                        end else begin
                            step <= step + 3'd1;
                            state <= S_ISSUE;
                        end
                    end
                end
                S_POLL: begin
                    // Status shows at any address while the flash is busy,
                    // so the target address is read and reused at the end.
                    // status read
                    cyc_start <= 1'b1;
                    cyc_read <= 1'b1;
                    cyc_addr <= user_addr;
                    cyc_data <= 8'h00;
                    state <= S_PWAIT;
                end
                S_PWAIT: begin
                    if (cyc_done) begin
                        last_rdata <= cyc_rdata;
                        prev_poll <= cyc_rdata;
                        // The first read only primes prev_poll. A flash
                        // whose toggle bit is stuck looks finished at
                        // once; only a read-back of the array proves the
                        // operation really took place.
                        if (first_poll) begin
                            first_poll <= 1'b0;
                            state <= S_POLL;
                        end else if (cyc_rdata[`FCSM_BIT_TOGGLE] ==
                                     prev_poll[`FCSM_BIT_TOGGLE]) begin
                            busy <= 1'b0;
                            done <= 1'b1;
                            state <= S_IDLE;
                        end else if (tle_seen) begin
                            tle_err <= 1'b1;
                            state <= S_RESET;
                        end else begin
                            tle_seen <= cyc_rdata[`FCSM_BIT_TLE];
                            state <= S_POLL;
                        end
                    end
                end
                S_RESET: begin
                    // One reset write only; software sees tle_err and
                    // decides whether to try the operation again.
                    // reset at any address
                    cyc_start <= 1'b1;
                    cyc_read <= 1'b0;
                    cyc_addr <= 19'h00000;
                    cyc_data <= `FCSM_CMD_RESET;
                    state <= S_RWAIT;
                end
                S_RWAIT: begin
                    if (cyc_done) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        state <= S_IDLE;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// file: rtl/fcsm_sync2.v
// Two-stage synchroniser for the flash data inputs.
`timescale 1ns/10ps
module fcsm_sync2 (
    input wire mclk_in,
    input wire srst_in,
    input wire [7:0] d_in,
    output reg [7:0] q_out
);
    reg [7:0] meta;

    always @(posedge mclk_in) begin
        if (srst_in) begin
            meta <= 8'h00;
            q_out <= 8'h00;
        end else begin
            meta <= d_in;
            q_out <= meta;
        end
    end
endmodule
